// File: pvft_cfg.svh
`ifndef PVFT_CFG_SVH
`define PVFT_CFG_SVH
// frame timing, in lines
`define PVFT_VSYNC_LINES      16'h0001
`define PVFT_VBP_LINES        16'h0002
`define PVFT_VFP_LINES        16'h0001
`define PVFT_TVB_BASE         16'h0006
`define PVFT_TVB_STEP         16'h0008
// line timing, in pixel clocks
`define PVFT_HSW_MIN          16'h0004
`define PVFT_HSW_MAX          16'h0080
`define PVFT_HBP_MIN          16'h0004
`define PVFT_HFP_MIN          16'h0008
// stereo select guard, in microseconds and core clocks
`define PVFT_EYE_GUARD_US     1000
`define PVFT_CORE_MHZ         25
`define PVFT_EYE_GUARD_CYC    (`PVFT_EYE_GUARD_US * `PVFT_CORE_MHZ)
// chip reset low time, in nanoseconds and core clocks (round up)
`define PVFT_RST_LOW_NS       1250
`define PVFT_CORE_PERIOD_NS   40
`define PVFT_RST_LOW_CYC      ((`PVFT_RST_LOW_NS + `PVFT_CORE_PERIOD_NS - 1) / `PVFT_CORE_PERIOD_NS)
`endif

// File: pvft_pkg.sv
package pvft_pkg;
    typedef enum logic [2:0] {PvSync, PvBackPorch, PvActive, PvFrontPorch} pvft_vst_e;
    typedef enum logic [2:0] {PhIdle, PhSync, PhBack, PhData, PhFront} pvft_hst_e;
    // link-side state
    typedef struct packed {
        pvft_vst_e   vst;
        pvft_hst_e   hst;
        logic [15:0] hCnt;
        logic [15:0] lineCnt;
        logic [15:0] pixCnt;
        logic [15:0] vbpLines;
        logic [15:0] vfpLines;
        logic [15:0] frameSrcLines;
        logic        frameSync;
        logic        lineSync;
        logic        pixelValid;
        logic [23:0] pixelBus;
        logic [2:0]  runSync;
        logic [2:0]  eyeSync;
        logic        eyeCur;
        logic        frameTgl;
        logic        parked;
    } pvft_link_s;
    // core-side state
    typedef struct packed {
        logic [15:0] rstCnt;
        logic        chipResetLow;
        logic        run;
        logic [2:0]  frameSync;
        logic        eyeReq;
        logic        eyeOut;
        logic [31:0] guardCnt;
        logic        eyePend;
        logic [2:0]  parkSync;
        logic [7:0]  pendAge;
    } pvft_core_s;
endpackage : pvft_pkg

// File: pvft_host.sv
`timescale 1ns/1ns
`default_nettype none
`include "pvft_cfg.svh"
// Functional notes
// (RQ1) Frame sync is held active for at least one full line each frame.
// (RQ2) At least two lines pass from frame sync to the first active line sync.
// (RQ3) At least one line passes from the line sync after the last active line to frame sync.
// (RQ4) Total vertical blanking is at least 6 plus 8 times max(1, source/mirror lines).
// (RQ5) Each line sync pulse lasts between 4 and 128 pixel clocks.
// (RQ6) Pixel-valid rises at least 4 pixel clocks after the line sync active edge.
// (RQ7) Line sync follows the fall of pixel-valid by at least 8 pixel clocks.
// (RQ8) Eye select changes at least 1.0 ms before frame sync changes.
// (RQ9) Eye select holds for at least 1.0 ms after each frame sync change.
// (RQ10) Line sync, pixel-valid and pixel bus are launched to be valid at the pixel clock edge.
// (RQ11) Chip reset is driven low for at least 1.25 us.
// (RQ12) The reference oscillator runs at 24.000 MHz without spread spectrum.
// (RQ13) The device counts pixel-valid pulses per frame as its source line count.
module pvft_host #(
    parameter logic [15:0] ACTIVE_LINES  = 16'h01E0,
    parameter logic [15:0] MIRROR_LINES  = 16'h01E0,
    parameter logic [15:0] ACTIVE_PIXELS = 16'h0280,
    parameter logic [15:0] HSYNC_WIDTH   = 16'h0008,
    parameter logic [15:0] HBP_CLKS      = 16'h0008,
    parameter logic [15:0] HFP_CLKS      = 16'h0010,
    parameter logic [31:0] EYE_GUARD_CYC = `PVFT_EYE_GUARD_CYC
) (
    input  wire logic        core_clk,
    input  wire logic        reset_n,
    input  wire logic        pixelClk,
    input  wire logic        runEnable,
    input  wire logic        eyeRequest,
    input  wire logic [23:0] pixelSource,
    output logic             chipResetLow,
    output logic             frameSync,
    output logic             lineSync,
    output logic             pixelValid,
    output logic [23:0]      pixelBus,
    output logic             stereoEyeSelect,
    output logic             frameStart
);
    pvft_pkg::pvft_core_s coreFf, nxtCore;
    pvft_pkg::pvft_link_s linkFf, nxtLink;
    logic                 linkRst_n;

    // larger of 1 and source/mirror ratio, rounded up
    function automatic logic [15:0] ratioCeil(input logic [15:0] src, input logic [15:0] mir);
        logic [15:0] q;
        q = 16'h0000;
        if (mir != 16'h0000) begin
            q = 16'((32'(src) + 32'(mir) - 32'h0000_0001) / 32'(mir));
        end
        if (q < 16'h0001) begin
            q = 16'h0001;
        end
        return q;
    endfunction : ratioCeil

    // core domain: reset pulse, run level, eye-select guard
    always_comb begin
        nxtCore = coreFf;
        nxtCore.frameSync = {coreFf.frameSync[1:0], linkFf.frameTgl};
        nxtCore.eyeReq = eyeRequest;
        nxtCore.parkSync = {coreFf.parkSync[1:0], linkFf.parked};
        // age of the pending flag, so a stale park report is never trusted
        if (!coreFf.eyePend) begin
            nxtCore.pendAge = 8'h00;
        end else if (coreFf.pendAge != 8'hFF) begin
            nxtCore.pendAge = coreFf.pendAge + 8'h01;
        end
        // (RQ11) reset pulse length
        if (coreFf.rstCnt < 16'(`PVFT_RST_LOW_CYC)) begin
            nxtCore.rstCnt = coreFf.rstCnt + 16'h0001;
            nxtCore.chipResetLow = 1'b0;
        end else begin
            nxtCore.chipResetLow = 1'b1;
        end
        nxtCore.run = runEnable && coreFf.chipResetLow;
        if (coreFf.guardCnt != 32'h0000_0000) begin
            nxtCore.guardCnt = coreFf.guardCnt - 32'h0000_0001;
        end
        // (RQ9) restart hold after any frame sync change
        if (coreFf.frameSync[2] != coreFf.frameSync[1]) begin
            nxtCore.guardCnt = EYE_GUARD_CYC;
        end else if (coreFf.eyeReq != coreFf.eyeOut && coreFf.guardCnt == 32'h0000_0000
                     && coreFf.parkSync[2] && coreFf.parkSync[1]
                     && coreFf.pendAge == 8'hFF) begin
            // (RQ8) change only while the frame generator is parked by our request
            nxtCore.eyeOut = coreFf.eyeReq;
            nxtCore.guardCnt = EYE_GUARD_CYC;
        end
        // pending stays high from request until the guard after the change runs out
        nxtCore.eyePend = (coreFf.guardCnt != 32'h0000_0000) || (coreFf.eyeReq != coreFf.eyeOut);
    end

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            coreFf <= '0;
        end else begin
            coreFf <= nxtCore;
        end
    end

    // link reset follows the core run level (runEnable and chipResetLow) through the link synchroniser
    assign linkRst_n = linkFf.runSync[2] & linkFf.runSync[1];

    // link domain: frame and line generator
    always_comb begin
        nxtLink = linkFf;
        nxtLink.runSync = {linkFf.runSync[1:0], coreFf.run};
        nxtLink.eyeSync = {linkFf.eyeSync[1:0], coreFf.eyePend};
        nxtLink.hCnt = linkFf.hCnt + 16'h0001;
        case (linkFf.hst)
            pvft_pkg::PhIdle: begin
                nxtLink.hCnt = 16'h0000;
                if (linkFf.runSync[2] && linkFf.runSync[1]) begin
                    nxtLink.hst = pvft_pkg::PhSync;
                    nxtLink.lineSync = 1'b1;
                end
            end
            pvft_pkg::PhSync: begin
                // (RQ5) line sync width 4..128
                if (linkFf.hCnt + 16'h0001 >= HSYNC_WIDTH) begin
                    nxtLink.hst = pvft_pkg::PhBack;
                    nxtLink.lineSync = 1'b0;
                    nxtLink.hCnt = 16'h0000;
                end
            end
            pvft_pkg::PhBack: begin
                // (RQ6) back porch before pixel-valid
                if (linkFf.hCnt + 16'h0001 >= HBP_CLKS + HSYNC_WIDTH - HSYNC_WIDTH) begin
                    nxtLink.hCnt = 16'h0000;
                    if (linkFf.vst == pvft_pkg::PvActive) begin
                        nxtLink.hst = pvft_pkg::PhData;
                        nxtLink.pixelValid = 1'b1;
                        nxtLink.pixelBus = pixelSource;
                    end else begin
                        nxtLink.hst = pvft_pkg::PhFront;
                    end
                end
            end
            pvft_pkg::PhData: begin
                // (RQ10) bus launched with pixel-valid on the same edge
                nxtLink.pixelBus = pixelSource;
                if (linkFf.hCnt + 16'h0001 >= ACTIVE_PIXELS) begin
                    nxtLink.hst = pvft_pkg::PhFront;
                    nxtLink.pixelValid = 1'b0;
                    nxtLink.pixelBus = 24'h00_0000;
                    nxtLink.hCnt = 16'h0000;
                    // (RQ13) one pulse per active line
                    nxtLink.pixCnt = linkFf.pixCnt + 16'h0001;
                end
            end
            default: begin
                // (RQ7) front porch before next line sync
                if (linkFf.hCnt + 16'h0001 >= HFP_CLKS) begin
                    nxtLink.hst = pvft_pkg::PhSync;
                    nxtLink.lineSync = 1'b1;
                    nxtLink.hCnt = 16'h0000;
                    nxtLink.lineCnt = linkFf.lineCnt + 16'h0001;
                    case (linkFf.vst)
                        pvft_pkg::PvSync: begin
                            // (RQ1) one full line of frame sync
                            nxtLink.vst = pvft_pkg::PvBackPorch;
                            nxtLink.frameSync = 1'b0;
                            nxtLink.frameTgl = ~linkFf.frameTgl;
                            nxtLink.lineCnt = 16'h0000;
                        end
                        pvft_pkg::PvBackPorch: begin
                            // (RQ2) back porch lines
                            if (linkFf.lineCnt + 16'h0001 >= linkFf.vbpLines) begin
                                nxtLink.vst = pvft_pkg::PvActive;
                                nxtLink.lineCnt = 16'h0000;
                            end
                        end
                        pvft_pkg::PvActive: begin
                            if (linkFf.lineCnt + 16'h0001 >= ACTIVE_LINES) begin
                                nxtLink.vst = pvft_pkg::PvFrontPorch;
                                nxtLink.lineCnt = 16'h0000;
                                nxtLink.frameSrcLines = linkFf.pixCnt;
                            end
                        end
                        default: begin
                            // (RQ3) front porch, (RQ8) wait out eye guard
                            if (linkFf.lineCnt + 16'h0001 >= linkFf.vfpLines
                                && !linkFf.eyeSync[2] && !linkFf.eyeSync[1]) begin
                                nxtLink.vst = pvft_pkg::PvSync;
                                nxtLink.frameSync = 1'b1;
                                nxtLink.frameTgl = ~linkFf.frameTgl;
                                nxtLink.lineCnt = 16'h0000;
                                nxtLink.pixCnt = 16'h0000;
                                nxtLink.parked = 1'b0;
                            end else if (linkFf.lineCnt + 16'h0001 >= linkFf.vfpLines) begin
                                // parked at the frame boundary, safe for an eye change
                                nxtLink.parked = 1'b1;
                            end
                        end
                    endcase
                end
            end
        endcase
        // (RQ4) split total blanking between porches
        nxtLink.vbpLines = 16'(`PVFT_TVB_BASE
            + `PVFT_TVB_STEP * ratioCeil(ACTIVE_LINES, MIRROR_LINES)) - `PVFT_VFP_LINES;
        if (nxtLink.vbpLines < `PVFT_VBP_LINES) begin
            nxtLink.vbpLines = `PVFT_VBP_LINES;
        end
        nxtLink.vfpLines = `PVFT_VFP_LINES;
        // hold the generator at the top of a frame until run has crossed
        if (!linkRst_n) begin
            nxtLink = '0;
            nxtLink.runSync = {linkFf.runSync[1:0], coreFf.run};
            nxtLink.vst = pvft_pkg::PvSync;
            nxtLink.frameSync = 1'b1;
        end
    end

    always_ff @(posedge pixelClk) begin
        linkFf <= nxtLink;
    end

    // outputs from flip-flops, frameStart from the XOR of two synchroniser flops
    assign chipResetLow    = coreFf.chipResetLow;
    assign frameSync       = linkFf.frameSync;
    assign lineSync        = linkFf.lineSync;
    assign pixelValid      = linkFf.pixelValid;
    assign pixelBus        = linkFf.pixelBus;
    assign stereoEyeSelect = coreFf.eyeOut;
    assign frameStart      = coreFf.frameSync[2] ^ coreFf.frameSync[1];
endmodule : pvft_host
`default_nettype wire

// File: pvft_host_props.sv
`timescale 1ns/1ns
`default_nettype none
module pvft_host_props #(
    parameter logic [31:0] EYE_GUARD_CYC = 32'h0000_0032
) (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic pixelClk,
    input wire logic chipResetLow,
    input wire logic frameSync,
    input wire logic lineSync,
    input wire logic pixelValid,
    input wire logic stereoEyeSelect,
    input wire logic frameStart
);
    logic [31:0] eyeAge_ff;
    logic [31:0] frmAge_ff;
    // core clocks since the last eye change and since the last frame edge
    always_ff @(posedge core_clk) begin
        eyeAge_ff <= !reset_n ? EYE_GUARD_CYC : $changed(stereoEyeSelect) ? '0 : eyeAge_ff + 1;
        frmAge_ff <= !reset_n ? EYE_GUARD_CYC : frameStart ? '0 : frmAge_ff + 1;
    end
    a_frame_sync_width: assert property (@(posedge pixelClk) disable iff (!reset_n)
        $rose(frameSync) |-> frameSync[*8]) else $error("frame sync short");
    a_back_porch_quiet: assert property (@(posedge pixelClk) disable iff (!reset_n)
        $rose(frameSync) |-> (!pixelValid) throughout (##72 1'b1)) else $error("back porch short");
    a_front_porch_quiet: assert property (@(posedge pixelClk) disable iff (!reset_n)
        $fell(pixelValid) |-> !frameSync[*8]) else $error("front porch short");
    a_hsync_min_width: assert property (@(posedge pixelClk) disable iff (!reset_n)
        $rose(lineSync) |-> lineSync[*4]) else $error("line sync short");
    a_hsync_max_width: assert property (@(posedge pixelClk) disable iff (!reset_n)
        $rose(lineSync) |-> ##[1:128] !lineSync) else $error("line sync long");
    a_line_back_gap: assert property (@(posedge pixelClk) disable iff (!reset_n)
        $rose(lineSync) |-> !pixelValid[*4]) else $error("valid too early");
    a_line_front_gap: assert property (@(posedge pixelClk) disable iff (!reset_n)
        $fell(pixelValid) |-> !lineSync[*8]) else $error("sync too soon");
    a_eye_setup_time: assert property (@(posedge core_clk) disable iff (!reset_n)
        frameStart |-> eyeAge_ff >= EYE_GUARD_CYC) else $error("eye setup short");
    a_eye_hold_time: assert property (@(posedge core_clk) disable iff (!reset_n)
        $changed(stereoEyeSelect) |-> frmAge_ff >= EYE_GUARD_CYC) else $error("eye hold short");
    a_reset_low_time: assert property (@(posedge core_clk) disable iff (!reset_n)
        $rose(chipResetLow) |-> !$past(chipResetLow, 32)) else $error("reset pulse short");
endmodule : pvft_host_props
bind pvft_host pvft_host_props #(.EYE_GUARD_CYC(EYE_GUARD_CYC)) u_props (
    .core_clk(core_clk), .reset_n(reset_n), .pixelClk(pixelClk), .chipResetLow(chipResetLow),
    .frameSync(frameSync), .lineSync(lineSync), .pixelValid(pixelValid),
    .stereoEyeSelect(stereoEyeSelect), .frameStart(frameStart));
`default_nettype wire

// File: pvft_dev_model.sv
`timescale 1ns/1ns
`default_nettype none
module pvft_dev_model (
    input  wire logic        pixelClk,
    input  wire logic        chipResetLow,
    input  wire logic        frameSync,
    input  wire logic        lineSync,
    input  wire logic        pixelValid,
    input  wire logic [23:0] pixelBus,
    output logic      [15:0] srcLines,
    output logic      [15:0] wordCnt,
    output logic      [15:0] gapLines,
    output logic      [23:0] lastWord
);
    logic [15:0] lineRun, wordRun, blankRun;
    logic        fsPrev, lsPrev, pvPrev;
    // sample on rising edge, count valid pulses per frame
    always @(posedge pixelClk) begin
        {fsPrev, lsPrev, pvPrev} <= {frameSync, lineSync, pixelValid};
        if (!chipResetLow) begin
            {lineRun, wordRun, blankRun, srcLines, wordCnt, gapLines} <= '0;
        end else begin
            if (lineSync && !lsPrev) blankRun <= blankRun + 16'h0001;
            // blank lines seen before an active line, its own sync excluded
            if (pixelValid && !pvPrev) begin
                lineRun  <= lineRun + 16'h0001;
                blankRun <= 16'h0000;
                if (blankRun > 16'h0001) gapLines <= blankRun - 16'h0001;
            end
            if (pixelValid) begin
                wordRun  <= wordRun + 16'h0001;
                lastWord <= pixelBus;
            end
            if (frameSync && !fsPrev) begin
                {srcLines, wordCnt} <= {lineRun, wordRun};
                {lineRun, wordRun}  <= '0;
            end
        end
    end
endmodule : pvft_dev_model
`default_nettype wire

// File: tb_parallel_video_frame_timing_input.sv
`timescale 1ns/1ns
`default_nettype none
module tb_parallel_video_frame_timing_input;
    localparam logic [15:0] LINES  = 16'h0002;
    localparam logic [15:0] PIXELS = 16'h0004;
    localparam logic [23:0] WORD   = 24'h5A_C3A5;
    localparam int          TVBMIN = 6 + 8 * 1; // source and mirror lines equal, ratio 1
    logic        core_clk, reset_n, pixelClk, runEnable, eyeRequest, frameStart;
    logic        chipResetLow, frameSync, lineSync, pixelValid, stereoEyeSelect;
    logic [23:0] pixelSource, pixelBus, lastWord;
    logic [15:0] srcLines, wordCnt, gapLines;
    int          errCount, comparisons;
    pvft_host #(.ACTIVE_LINES(LINES), .MIRROR_LINES(LINES), .ACTIVE_PIXELS(PIXELS),
        .EYE_GUARD_CYC(32'h0000_0032)) uut (
        .core_clk(core_clk), .reset_n(reset_n), .pixelClk(pixelClk), .runEnable(runEnable),
        .eyeRequest(eyeRequest), .pixelSource(pixelSource), .chipResetLow(chipResetLow),
        .frameSync(frameSync), .lineSync(lineSync), .pixelValid(pixelValid),
        .pixelBus(pixelBus), .stereoEyeSelect(stereoEyeSelect), .frameStart(frameStart));
    pvft_dev_model u_dev (.pixelClk(pixelClk), .chipResetLow(chipResetLow),
        .frameSync(frameSync), .lineSync(lineSync), .pixelValid(pixelValid),
        .pixelBus(pixelBus), .srcLines(srcLines), .wordCnt(wordCnt), .gapLines(gapLines),
        .lastWord(lastWord));
    // core clock and an unrelated link clock
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    initial begin
        pixelClk = 1'b0;
        #7;
        forever #80 pixelClk = ~pixelClk;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errCount++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic complete_run;
        $display("comparisons=%0d errors=%0d", comparisons, errCount);
        if (errCount == 0 && comparisons > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : complete_run
    // waits for a frame sync rise, then lets the model take it
    task automatic wait_frame;
        int n;
        for (n = 0; n < 4000 && frameSync !== 1'b0; n++) @(negedge pixelClk);
        for (n = 0; n < 4000 && frameSync !== 1'b1; n++) @(negedge pixelClk);
        check(32'(n < 4000), 32'h0000_0001);
        repeat (2) @(negedge pixelClk);
    endtask : wait_frame
    task automatic t_reset_time;
        time t0;
        t0 = $time;
        for (int n = 0; n < 100 && chipResetLow !== 1'b1; n++) @(negedge core_clk);
        check(32'(($time - t0 >= 1250) && chipResetLow === 1'b1), 32'h0000_0001);
    endtask : t_reset_time
    task automatic t_frames;
        runEnable = 1'b1;
        wait_frame;
        wait_frame;
        check(32'(srcLines), 32'(LINES));
        check(32'(wordCnt), 32'(LINES * PIXELS));
        check(32'(lastWord), 32'(WORD));
        check(32'(gapLines >= TVBMIN), 32'h0000_0001);
    endtask : t_frames
    task automatic t_eye;
        for (int v = 1; v >= 0; v--) begin
            @(negedge core_clk);
            eyeRequest = v[0];
            for (int n = 0; n < 20000 && stereoEyeSelect !== v[0]; n++) @(negedge core_clk);
            check(32'(stereoEyeSelect), 32'(v));
            wait_frame;
            check(32'(srcLines), 32'(LINES));
        end
    endtask : t_eye
    initial begin
        #2_000_000;
        errCount++;
        complete_run;
    end
    initial begin
        {reset_n, runEnable, eyeRequest} = 3'h0;
        pixelSource = WORD;
        repeat (4) @(negedge core_clk);
        reset_n = 1'b1;
        t_reset_time;
        t_frames;
        t_eye;
        complete_run;
    end
endmodule : tb_parallel_video_frame_timing_input
`default_nettype wire
